// ===== logic/svq_pkg.sv
// Notes on behaviour
// RQ1: Host sleep pin forces bypass between ports.
// RQ2: Bypass drops port-3 destined frames unbuffered.
// RQ3: Sixteen-entry table maps VLAN to filter.
// RQ4: Untagged or null VLAN uses port default.
// RQ5: Invalid VLAN drops frame and skips learning.
// RQ6: Total miss floods to VLAN members.
// RQ7: Matching static entry forwards to static ports.
// RQ8: Otherwise dynamic hit forwards to learned port.
// RQ9: Learn new source, refresh known source stamp.
// RQ10: Per-port ingress filter and non-default discard.
// RQ11: Control bit zero splits four queues.
// RQ12: Unsplit port treats all frames equally.
// RQ13: Global bit three picks strict or weighted.
// RQ14: Port priority marks every frame high.
// RQ15: Tag priority translated through mapping registers.
// RQ16: Egress inserts default tag for selected sources.
// RQ17: Already tagged frames never get second tag.
// RQ18: Default tags held in register pairs.
// RQ19: Egress removal strips tags, untagged unchanged.
// RQ20: Inserted or removed frames regenerate checksum.
// RQ21: Ceiling caps priority at default tag priority.
// RQ22: Code point table decides DiffServ priority.
// RQ23: Highest enabled classifier priority wins.
package svq_pkg;
  // ==========================================================
  // Register indices; the byte address is four times the index.
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_GLOBAL5 = 10'h005;
  localparam logic [9:0] IDX_PMAP_LO = 10'h00c;
  localparam logic [9:0] IDX_PMAP_HI = 10'h00d;
  localparam logic [9:0] IDX_PORT_BASE = 10'h010;
  localparam logic [9:0] IDX_PORT_STRIDE = 10'h010;
  localparam logic [9:0] OFF_CTL0 = 10'h000;
  localparam logic [9:0] OFF_CTL2 = 10'h002;
  localparam logic [9:0] OFF_TAG_HI = 10'h003;
  localparam logic [9:0] OFF_TAG_LO = 10'h004;
  localparam logic [9:0] IDX_TOS_BASE = 10'h060;
  localparam logic [9:0] IDX_INS_SEL = 10'h0c2;
  localparam logic [9:0] IDX_VLAN_BASE = 10'h100;
  localparam logic [9:0] IDX_STATUS = 10'h110;
  localparam int TOS_REGS = 16;
  localparam int VLAN_ENTRIES = 16;
  // ==========================================================
  // Field positions.
  localparam int CTL0_SPLIT = 0;
  localparam int CTL0_REMOVE = 1;
  localparam int CTL0_INSERT = 2;
  localparam int CTL0_PPRIO_LO = 3;
  localparam int CTL0_DOT1P = 5;
  localparam int CTL0_DSCP = 6;
  localparam int CTL0_CEIL = 7;
  localparam int CTL2_DISC_NPVID = 5;
  localparam int CTL2_IN_FILTER = 6;
  localparam int GLB5_WFQ = 3;
  localparam int VL_VALID = 19;
  localparam int VL_MEMB_LO = 16;
  localparam int VL_FID_LO = 12;
  // ==========================================================
  // Reset values and bus answers.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [19:0] RST_VLAN = 20'h00000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] PRIO_HIGH = 2'h3;
endpackage

// ===== logic/svq_switch_fwd.sv
`timescale 1ns/1ps
`default_nettype none
module svq_switch_fwd
  import svq_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic port3_link_sleep_input_in,
  input wire logic [ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic frm_valid_in,
  input wire logic [1:0] frm_port_in,
  input wire logic frm_tagged_in,
  input wire logic [15:0] frm_tci_in,
  input wire logic frm_is_ip_in,
  input wire logic [7:0] frm_tos_in,
  input wire logic st_hit_in,
  input wire logic st_use_fid_in,
  input wire logic [3:0] st_fid_in,
  input wire logic [2:0] st_ports_in,
  input wire logic dyn_da_hit_in,
  input wire logic [1:0] dyn_da_port_in,
  input wire logic dyn_sa_hit_in,
  output logic dec_valid_out,
  output logic dec_drop_out,
  output logic [2:0] dec_dest_out,
  output logic [3:0] dec_fid_out,
  output logic [5:0] dec_queue_out,
  output logic [15:0] dec_tci_out,
  output logic [2:0] dec_strip_out,
  output logic [2:0] dec_insert_out,
  output logic [2:0] dec_crc_regen_out,
  output logic learn_add_out,
  output logic learn_refresh_out,
  output logic bypass_out,
  output logic wfq_mode_out,
  output logic [2:0] queue_split_out
);
  // ==========================================================
  // Helpers
  // Word index of a byte address; used for both write and read.
  function automatic logic [9:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bit in the insertion-select byte pairing an egress and a source port.
  function automatic logic [2:0] sel_bit(input int e, input logic [1:0] src);
    logic [1:0] k;
    k = (src < 2'(e)) ? src : 2'(src - 2'd1);
    return 3'(2 * e) + 3'(k);
  endfunction

  // ==========================================================
  // Sleep pin synchroniser
  logic slp_meta; // First stage, read only by the second.
  logic slp_sync; // Synchronised host sleep level.
  logic bypass; // Registered bypass mode.

  // The host pin is asynchronous, so it passes two flops first.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      slp_meta <= 1'b0;
      slp_sync <= 1'b0;
      bypass <= 1'b0;
    end else begin
      slp_meta <= port3_link_sleep_input_in;
      slp_sync <= slp_meta;
      bypass <= slp_sync; // RQ1
    end
  end

  // ==========================================================
  // Register file
  logic [7:0] ctl0 [3]; // Port control 0 per port.
  logic [7:0] ctl2 [3]; // Port control 2 per port.
  logic [15:0] deftag [3]; // Default tag per port.
  logic [7:0] glob5; // Global control.
  logic [15:0] pmap; // Two bits of queue per tag priority.
  logic [5:0] ins_sel; // Insertion source selection.
  logic [7:0] tos [TOS_REGS]; // Code point priority table.
  logic [19:0] vlan [VLAN_ENTRIES]; // VLAN table entries.
  logic [7:0] next_ctl0 [3];
  logic [7:0] next_ctl2 [3];
  logic [15:0] next_deftag [3];
  logic [7:0] next_glob5;
  logic [15:0] next_pmap;
  logic [5:0] next_ins_sel;
  logic [7:0] next_tos [TOS_REGS];
  logic [19:0] next_vlan [VLAN_ENTRIES];
  logic do_write; // Both halves of a write are held.
  logic [9:0] w_idx; // Held write index.
  logic [31:0] w_data; // Held write data.
  logic [3:0] w_strb; // Held write strobes.
  logic w_hit; // Write index is mapped.

  // Decodes a held write and updates the addressed register.
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    next_ctl0 = ctl0;
    next_ctl2 = ctl2;
    next_deftag = deftag;
    next_glob5 = glob5;
    next_pmap = pmap;
    next_ins_sel = ins_sel;
    next_tos = tos;
    next_vlan = vlan;
    w_hit = (w_idx == IDX_GLOBAL5) || (w_idx == IDX_PMAP_LO) || (w_idx == IDX_PMAP_HI) ||
            (w_idx == IDX_INS_SEL) || (w_idx == IDX_STATUS);
    for (int p = 0; p < 3; p++) begin
      if (w_idx == IDX_PORT_BASE + 10'(p) * IDX_PORT_STRIDE + OFF_CTL0) begin
        w_hit = 1'b1;
        if (do_write && w_strb[0]) begin
          next_ctl0[p] = w_data[7:0];
        end
      end
      if (w_idx == IDX_PORT_BASE + 10'(p) * IDX_PORT_STRIDE + OFF_CTL2) begin
        w_hit = 1'b1;
        if (do_write && w_strb[0]) begin
          next_ctl2[p] = w_data[7:0];
        end
      end
      if (w_idx == IDX_PORT_BASE + 10'(p) * IDX_PORT_STRIDE + OFF_TAG_HI) begin
        w_hit = 1'b1;
        if (do_write && w_strb[0]) begin
          next_deftag[p][15:8] = w_data[7:0]; // RQ18
        end
      end
      if (w_idx == IDX_PORT_BASE + 10'(p) * IDX_PORT_STRIDE + OFF_TAG_LO) begin
        w_hit = 1'b1;
        if (do_write && w_strb[0]) begin
          next_deftag[p][7:0] = w_data[7:0]; // RQ18
        end
      end
    end
    for (int t = 0; t < TOS_REGS; t++) begin
      if (w_idx == IDX_TOS_BASE + 10'(t)) begin
        w_hit = 1'b1;
        if (do_write && w_strb[0]) begin
          next_tos[t] = w_data[7:0];
        end
      end
    end
    for (int v = 0; v < VLAN_ENTRIES; v++) begin
      if (w_idx == IDX_VLAN_BASE + 10'(v)) begin
        w_hit = 1'b1;
        m = merge({12'h000, vlan[v]}, w_data, w_strb);
        if (do_write) begin
          next_vlan[v] = m[19:0]; // RQ3
        end
      end
    end
    if (do_write && w_strb[0]) begin
      if (w_idx == IDX_GLOBAL5) begin
        next_glob5 = w_data[7:0];
      end
      if (w_idx == IDX_PMAP_LO) begin
        next_pmap[7:0] = w_data[7:0];
      end
      if (w_idx == IDX_PMAP_HI) begin
        next_pmap[15:8] = w_data[7:0];
      end
      if (w_idx == IDX_INS_SEL) begin
        next_ins_sel = w_data[5:0];
      end
    end
  end

  // Registers the configuration state.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int p = 0; p < 3; p++) begin
        ctl0[p] <= RST_BYTE;
        ctl2[p] <= RST_BYTE;
        deftag[p] <= RST_HALF;
      end
      for (int t = 0; t < TOS_REGS; t++) begin
        tos[t] <= RST_BYTE;
      end
      for (int v = 0; v < VLAN_ENTRIES; v++) begin
        vlan[v] <= RST_VLAN;
      end
      glob5 <= RST_BYTE;
      pmap <= RST_HALF;
      ins_sel <= 6'h00;
    end else begin
      ctl0 <= next_ctl0;
      ctl2 <= next_ctl2;
      deftag <= next_deftag;
      tos <= next_tos;
      vlan <= next_vlan;
      glob5 <= next_glob5;
      pmap <= next_pmap;
      ins_sel <= next_ins_sel;
    end
  end

  // ==========================================================
  // Read decode
  logic [9:0] r_idx; // Index of the offered read address.
  logic [31:0] r_word; // Word at that index.
  logic r_hit; // Read index is mapped.

  // Chooses the read word; narrow registers sit in the low byte.
  always_comb begin
    r_idx = idx_of(axi_araddr_in);
    r_word = 32'h0;
    r_hit = 1'b1;
    if (r_idx == IDX_GLOBAL5) begin
      r_word[7:0] = glob5;
    end else if (r_idx == IDX_PMAP_LO) begin
      r_word[7:0] = pmap[7:0];
    end else if (r_idx == IDX_PMAP_HI) begin
      r_word[7:0] = pmap[15:8];
    end else if (r_idx == IDX_INS_SEL) begin
      r_word[5:0] = ins_sel;
    end else if (r_idx == IDX_STATUS) begin
      r_word[0] = bypass;
    end else begin
      r_hit = 1'b0;
    end
    for (int p = 0; p < 3; p++) begin
      for (int o = 0; o < 5; o++) begin
        if (r_idx == IDX_PORT_BASE + 10'(p) * IDX_PORT_STRIDE + 10'(o)) begin
          r_hit = (10'(o) != 10'h001);
          r_word[7:0] = (10'(o) == OFF_CTL0) ? ctl0[p] :
                        (10'(o) == OFF_CTL2) ? ctl2[p] :
                        (10'(o) == OFF_TAG_HI) ? deftag[p][15:8] :
                        (10'(o) == OFF_TAG_LO) ? deftag[p][7:0] : 8'h00;
        end
      end
    end
    for (int t = 0; t < TOS_REGS; t++) begin
      if (r_idx == IDX_TOS_BASE + 10'(t)) begin
        r_hit = 1'b1;
        r_word[7:0] = tos[t];
      end
    end
    for (int v = 0; v < VLAN_ENTRIES; v++) begin
      if (r_idx == IDX_VLAN_BASE + 10'(v)) begin
        r_hit = 1'b1;
        r_word[19:0] = vlan[v];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite handshakes
  logic aw_full, w_full;
  logic next_aw_full, next_w_full, next_awready, next_wready, next_bvalid;
  logic next_arready, next_rvalid;
  logic [9:0] next_w_idx;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;

  // Holds address and data separately, writes when both are in, one at a time.
  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_w_idx = w_idx;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = axi_bvalid_out;
    next_bresp = axi_bresp_out;
    next_arready = axi_arready_out;
    next_rvalid = axi_rvalid_out;
    next_rdata = axi_rdata_out;
    next_rresp = axi_rresp_out;
    do_write = aw_full && w_full && !axi_bvalid_out;
    if (axi_awvalid_in && axi_awready_out) begin
      next_aw_full = 1'b1;
      next_w_idx = idx_of(axi_awaddr_in);
    end
    if (axi_wvalid_in && axi_wready_out) begin
      next_w_full = 1'b1;
      next_w_data = axi_wdata_in;
      next_w_strb = axi_wstrb_in;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = w_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_bvalid_out && axi_bready_in) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
    if (axi_arvalid_in && axi_arready_out) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = r_hit ? r_word : 32'h0;
      next_rresp = r_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_rvalid_out && axi_rready_in) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Registers the bus state.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      w_idx <= 10'h000;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      axi_awready_out <= 1'b0;
      axi_wready_out <= 1'b0;
      axi_bvalid_out <= 1'b0;
      axi_bresp_out <= RESP_OKAY;
      axi_arready_out <= 1'b0;
      axi_rvalid_out <= 1'b0;
      axi_rdata_out <= 32'h0;
      axi_rresp_out <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      w_idx <= next_w_idx;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      axi_awready_out <= next_awready;
      axi_wready_out <= next_wready;
      axi_bvalid_out <= next_bvalid;
      axi_bresp_out <= next_bresp;
      axi_arready_out <= next_arready || (!axi_arready_out && !axi_rvalid_out);
      axi_rvalid_out <= next_rvalid;
      axi_rdata_out <= next_rdata;
      axi_rresp_out <= next_rresp;
    end
  end

  // ==========================================================
  // Frame classification and forwarding decision
  logic [1:0] ip; // Ingress port index, 0 to 2.
  logic [11:0] eff_vid; // VLAN used for lookup.
  logic vl_hit; // VLAN entry found and valid.
  logic [3:0] filter_identifier; // Resolved filter_identifier.
  logic [2:0] memb; // VLAN membership ports.
  logic [2:0] dest; // Destination set.
  logic drop; // Frame is discarded.
  logic [1:0] prio; // Highest enabled class.
  logic [2:0] pcp; // Tag priority after the ceiling.
  logic [15:0] tag_control_info; // Outgoing tag_control_info.
  logic [5:0] queue; // Per-egress queue choice.
  logic [2:0] strip, ins; // Per-egress tag actions.
  logic [1:0] q_1p, q_ds; // Classifier results.

  // Resolves VLAN, destination, class and tag actions for one frame.
  always_comb begin
    ip = (frm_port_in == 2'd3) ? 2'd0 : frm_port_in;
    eff_vid = (frm_tagged_in && frm_tci_in[11:0] != 12'h000) ?
              frm_tci_in[11:0] : deftag[ip][11:0]; // RQ4
    vl_hit = 1'b0;
    filter_identifier = 4'h0;
    memb = 3'h0;
    for (int v = VLAN_ENTRIES - 1; v >= 0; v--) begin
      if (vlan[v][VL_VALID] && vlan[v][11:0] == eff_vid) begin
        vl_hit = 1'b1; // RQ3
        filter_identifier = vlan[v][VL_FID_LO +: 4];
        memb = vlan[v][VL_MEMB_LO +: 3];
      end
    end
    if (st_hit_in && (!st_use_fid_in || st_fid_in == filter_identifier)) begin
      dest = st_ports_in; // RQ7
    end else if (dyn_da_hit_in) begin
      dest = 3'(3'b001 << dyn_da_port_in); // RQ8
    end else begin
      dest = memb; // RQ6
    end
    if (bypass) begin
      dest[2] = 1'b0; // RQ2
    end
    drop = !vl_hit || (frm_port_in == 2'd3) || (dest == 3'h0) || // RQ5
           (ctl2[ip][CTL2_IN_FILTER] && !memb[ip]) || // RQ10
           (ctl2[ip][CTL2_DISC_NPVID] && frm_tagged_in && eff_vid != deftag[ip][11:0]);
    pcp = (ctl0[ip][CTL0_CEIL] && frm_tci_in[15:13] > deftag[ip][15:13]) ?
          deftag[ip][15:13] : frm_tci_in[15:13]; // RQ21
    q_1p = (ctl0[ip][CTL0_DOT1P] && frm_tagged_in) ? pmap[2*pcp +: 2] : 2'h0; // RQ15
    q_ds = (ctl0[ip][CTL0_DSCP] && frm_is_ip_in) ?
           tos[frm_tos_in[7:4]][2*frm_tos_in[3:2] +: 2] : 2'h0; // RQ22
    prio = (ctl0[ip][CTL0_PPRIO_LO +: 2] != 2'h0) ? PRIO_HIGH : 2'h0; // RQ14
    if (q_1p > prio) begin
      prio = q_1p; // RQ23
    end
    if (q_ds > prio) begin
      prio = q_ds; // RQ23
    end
    tag_control_info = frm_tagged_in ? {pcp, frm_tci_in[12:0]} : deftag[ip];
    for (int e = 0; e < 3; e++) begin
      queue[2*e +: 2] = ctl0[e][CTL0_SPLIT] ? prio : 2'h0; // RQ11 RQ12
      strip[e] = frm_tagged_in && ctl0[e][CTL0_REMOVE]; // RQ19
      ins[e] = !frm_tagged_in && ctl0[e][CTL0_INSERT] && (2'(e) != ip) &&
               ins_sel[sel_bit(e, ip)]; // RQ16 RQ17
    end
  end

  // Registers the decision one cycle after the frame is offered.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dec_valid_out <= 1'b0;
      dec_drop_out <= 1'b0;
      dec_dest_out <= 3'h0;
      dec_fid_out <= 4'h0;
      dec_queue_out <= 6'h00;
      dec_tci_out <= 16'h0000;
      dec_strip_out <= 3'h0;
      dec_insert_out <= 3'h0;
      dec_crc_regen_out <= 3'h0;
      learn_add_out <= 1'b0;
      learn_refresh_out <= 1'b0;
      bypass_out <= 1'b0;
      wfq_mode_out <= 1'b0;
      queue_split_out <= 3'h0;
    end else begin
      dec_valid_out <= frm_valid_in;
      dec_drop_out <= frm_valid_in && drop;
      dec_dest_out <= (frm_valid_in && !drop) ? dest : 3'h0;
      dec_fid_out <= filter_identifier;
      dec_queue_out <= queue;
      dec_tci_out <= tag_control_info;
      dec_strip_out <= (frm_valid_in && !drop) ? (strip & dest) : 3'h0;
      dec_insert_out <= (frm_valid_in && !drop) ? (ins & dest) : 3'h0;
      dec_crc_regen_out <= (frm_valid_in && !drop) ? ((strip | ins) & dest) : 3'h0; // RQ20
      learn_add_out <= frm_valid_in && vl_hit && !dyn_sa_hit_in; // RQ9
      learn_refresh_out <= frm_valid_in && vl_hit && dyn_sa_hit_in; // RQ9
      bypass_out <= bypass;
      wfq_mode_out <= glob5[GLB5_WFQ]; // RQ13
      queue_split_out <= {ctl0[2][CTL0_SPLIT], ctl0[1][CTL0_SPLIT], ctl0[0][CTL0_SPLIT]};
    end
  end
endmodule
`default_nettype wire

// ===== dv/svq_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far side: the host sleep pin and lookup results.
module svq_far_model
  import svq_pkg::*;
(
  input wire logic clk_in,
  input wire logic sleep_req_in,
  input wire logic [1:0] sel_in,
  output logic sleep_out,
  output logic st_hit_out,
  output logic st_use_fid_out,
  output logic [3:0] st_fid_out,
  output logic [2:0] st_ports_out,
  output logic dyn_da_hit_out,
  output logic [1:0] dyn_da_port_out,
  output logic dyn_sa_hit_out
);
  // The host raises its pin from its own clocked logic while it sleeps.
  always_ff @(posedge clk_in) begin
    sleep_out <= sleep_req_in;
  end
  // Case 0 misses, 1 hits static, 2 hits static with a foreign filter, 3 knows the source.
  assign st_hit_out = (sel_in == 2'h1) || (sel_in == 2'h2);
  assign st_use_fid_out = (sel_in == 2'h2);
  assign st_fid_out = 4'hf;
  assign st_ports_out = 3'h4;
  assign dyn_da_hit_out = (sel_in == 2'h2);
  assign dyn_da_port_out = 2'h1;
  assign dyn_sa_hit_out = (sel_in == 2'h3);
endmodule
`default_nettype wire

// ===== dv/svq_switch_fwd_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker on the decision and bypass ports.
module svq_fwd_chk
  import svq_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic port3_link_sleep_input_in,
  input wire logic frm_valid_in,
  input wire logic frm_tagged_in,
  input wire logic st_hit_in,
  input wire logic st_use_fid_in,
  input wire logic [2:0] st_ports_in,
  input wire logic dyn_sa_hit_in,
  input wire logic dec_valid_out,
  input wire logic dec_drop_out,
  input wire logic [2:0] dec_dest_out,
  input wire logic [5:0] dec_queue_out,
  input wire logic [2:0] dec_strip_out,
  input wire logic [2:0] dec_insert_out,
  input wire logic [2:0] dec_crc_regen_out,
  input wire logic learn_add_out,
  input wire logic bypass_out,
  input wire logic [2:0] queue_split_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_bypass_on; port3_link_sleep_input_in [*5] |-> bypass_out; endproperty
  a_bypass_on: assert property (p_bypass_on) else $error("bypass not entered");
  property p_bypass_off; (!port3_link_sleep_input_in) [*5] |-> !bypass_out; endproperty
  a_bypass_off: assert property (p_bypass_off) else $error("bypass not left");
  property p_bypass_p3; bypass_out && dec_valid_out |-> !dec_dest_out[2]; endproperty
  a_bypass_p3: assert property (p_bypass_p3) else $error("port 3 reached in bypass");
  property p_dec; frm_valid_in |=> dec_valid_out; endproperty
  a_dec: assert property (p_dec) else $error("no decision one cycle after frame");
  property p_static;
    frm_valid_in && st_hit_in && !st_use_fid_in |=>
      dec_drop_out || bypass_out || (dec_dest_out == $past(st_ports_in));
  endproperty
  a_static: assert property (p_static) else $error("static ports not used");
  property p_known_sa; frm_valid_in && dyn_sa_hit_in |=> !learn_add_out; endproperty
  a_known_sa: assert property (p_known_sa) else $error("known source added again");
  property p_unsplit;
    dec_valid_out |-> (queue_split_out[0] || dec_queue_out[1:0] == 2'h0)
      && (queue_split_out[1] || dec_queue_out[3:2] == 2'h0)
      && (queue_split_out[2] || dec_queue_out[5:4] == 2'h0);
  endproperty
  a_unsplit: assert property (p_unsplit) else $error("unsplit port used a queue");
  property p_no_retag; dec_valid_out && $past(frm_tagged_in) |-> dec_insert_out == 3'h0; endproperty
  a_no_retag: assert property (p_no_retag) else $error("second tag inserted");
  property p_no_strip; dec_valid_out && !$past(frm_tagged_in) |-> dec_strip_out == 3'h0; endproperty
  a_no_strip: assert property (p_no_strip) else $error("untagged frame stripped");
  property p_crc; dec_valid_out |-> dec_crc_regen_out == (dec_strip_out | dec_insert_out); endproperty
  a_crc: assert property (p_crc) else $error("checksum regeneration mismatch");
endmodule
bind svq_switch_fwd svq_fwd_chk u_svq_fwd_chk (.*);
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import svq_pkg::*;
  // ==========================================
  // Signals carry the port names so the instance connects by name.
  logic clk_in = 0, sys_rst_in = 1, axi_awvalid_in = 0, axi_wvalid_in = 0, axi_bready_in = 0;
  logic axi_arvalid_in = 0, axi_rready_in = 0, frm_valid_in = 0, frm_tagged_in = 0, sleep_req = 0;
  logic [ADDR_W-1:0] axi_awaddr_in = 12'h000, axi_araddr_in = 12'h000;
  logic [31:0] axi_wdata_in = 32'h0, axi_rdata_out;
  logic [3:0] axi_wstrb_in = 4'hf, st_fid_in, dec_fid_out;
  logic [1:0] frm_port_in = 2'h0, sel = 2'h0, axi_bresp_out, axi_rresp_out, dyn_da_port_in;
  logic [15:0] frm_tci_in = 16'h0, dec_tci_out;
  logic [7:0] frm_tos_in = 8'h0;
  logic [2:0] st_ports_in, dec_dest_out, dec_strip_out, dec_insert_out, dec_crc_regen_out;
  logic [2:0] queue_split_out;
  logic [5:0] dec_queue_out;
  logic frm_is_ip_in = 0, port3_link_sleep_input_in, st_hit_in, st_use_fid_in, dyn_da_hit_in;
  logic dyn_sa_hit_in, axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out;
  logic axi_rvalid_out, dec_valid_out, dec_drop_out, learn_add_out, learn_refresh_out;
  logic bypass_out, wfq_mode_out;
  int errors = 0, check_count = 0, cycles = 0;
  svq_switch_fwd u_svq_switch_fwd (.*);
  svq_far_model u_svq_far_model (.clk_in(clk_in), .sleep_req_in(sleep_req), .sel_in(sel),
    .sleep_out(port3_link_sleep_input_in), .st_hit_out(st_hit_in), .st_use_fid_out(st_use_fid_in),
    .st_fid_out(st_fid_in), .st_ports_out(st_ports_in), .dyn_da_hit_out(dyn_da_hit_in),
    .dyn_da_port_out(dyn_da_port_in), .dyn_sa_hit_out(dyn_sa_hit_in));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Bus and frame drivers; the bus drivers hold their request until the handshake edge, the frame driver offers its frame for one cycle.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_in);
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1'b1;
    axi_wvalid_in <= 1'b1;
    axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (axi_awready_out === 1'b1) axi_awvalid_in <= 1'b0;
      if (axi_wready_out === 1'b1) axi_wvalid_in <= 1'b0;
    end while (axi_bvalid_out !== 1'b1);
    axi_bready_in <= 1'b0;
    `CHK(axi_bresp_out, r)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_in);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'b1;
    axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (axi_arready_out === 1'b1) axi_arvalid_in <= 1'b0;
    end while (axi_rvalid_out !== 1'b1);
    axi_rready_in <= 1'b0;
    `CHK(axi_rdata_out, d)
    `CHK(axi_rresp_out, r)
  endtask
  task automatic fr(input logic [1:0] p, input logic t, input logic [15:0] tag_control_info,
      input logic [1:0] s, input logic [2:0] dst, input logic drp, input logic lrn);
    @(posedge clk_in);
    frm_valid_in <= 1'b1;
    frm_port_in <= p;
    frm_tagged_in <= t;
    frm_tci_in <= tag_control_info;
    sel <= s;
    @(posedge clk_in);
    frm_valid_in <= 1'b0;
    #1;
    `CHK(dec_valid_out, 1'b1)
    `CHK(dec_dest_out, dst)
    `CHK(dec_drop_out, drp)
    `CHK(learn_add_out, lrn)
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_regs();
    rd(12'h040, 32'h0, RESP_OKAY);
    rd(12'hffc, 32'h0, RESP_SLVERR);
    wr(12'hffc, 32'h1, RESP_SLVERR);
    wr(12'h04c, 32'h20, RESP_OKAY);
    wr(12'h050, 32'h05, RESP_OKAY);
    rd(12'h050, 32'h05, RESP_OKAY);
    wr(12'h400, 32'h000b3005, RESP_OKAY);
    rd(12'h400, 32'h000b3005, RESP_OKAY);
  endtask
  task automatic t_lookup();
    logic [2:0] exp_d [4] = '{3'h3, 3'h4, 3'h2, 3'h3};
    for (int i = 0; i < 4; i++) begin
      fr(2'h0, 1'b1, 16'h0005, i[1:0], exp_d[i], 1'b0, i != 3);
      `CHK(dec_fid_out, 4'h3)
      `CHK(learn_refresh_out, i == 3)
    end
    fr(2'h0, 1'b1, 16'h0007, 2'h0, 3'h0, 1'b1, 1'b0);
    fr(2'h0, 1'b0, 16'h0000, 2'h0, 3'h3, 1'b0, 1'b1);
    `CHK(dec_tci_out, 16'h2005)
  endtask
  task automatic t_prio();
    wr(12'h040, 32'h8b, RESP_OKAY);
    wr(12'h080, 32'h04, RESP_OKAY);
    wr(12'h308, 32'h04, RESP_OKAY);
    wr(12'h014, 32'h08, RESP_OKAY);
    #1;
    `CHK(wfq_mode_out, 1'b1)
    `CHK(queue_split_out, 3'h1)
    fr(2'h0, 1'b0, 16'h0000, 2'h0, 3'h3, 1'b0, 1'b1);
    `CHK(dec_insert_out, 3'h2)
    `CHK(dec_crc_regen_out, 3'h2)
    `CHK(dec_queue_out, 6'h03)
    fr(2'h0, 1'b1, 16'he005, 2'h0, 3'h3, 1'b0, 1'b1);
    `CHK(dec_tci_out, 16'h2005)
    `CHK(dec_insert_out, 3'h0)
    `CHK(dec_strip_out, 3'h1)
    `CHK(dec_crc_regen_out, 3'h1)
    wr(12'h040, 32'ha3, RESP_OKAY);
    wr(12'h030, 32'h08, RESP_OKAY);
    fr(2'h0, 1'b1, 16'he005, 2'h0, 3'h3, 1'b0, 1'b1);
    `CHK(dec_queue_out, 6'h02)
  endtask
  task automatic t_bypass();
    sleep_req <= 1'b1;
    repeat (6) @(posedge clk_in);
    `CHK(bypass_out, 1'b1)
    rd(12'h440, 32'h1, RESP_OKAY);
    fr(2'h0, 1'b1, 16'h0005, 2'h1, 3'h0, 1'b1, 1'b1);
    sleep_req <= 1'b0;
    repeat (6) @(posedge clk_in);
    `CHK(bypass_out, 1'b0)
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    t_regs();
    t_lookup();
    t_prio();
    t_bypass();
    wrap_up();
  end
endmodule
`default_nettype wire
